// [hdl/lock_assist_regs.vh]
// Register indices, field positions, reset values and codes of the
// lock assist and readback block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef LOCK_ASSIST_REGS_VH
`define LOCK_ASSIST_REGS_VH

// ****************************************************************
// Register indices
// ****************************************************************
`define REG_FREQ        4'h0
`define REG_GAIN        4'h1
`define REG_SETTLE      4'h2
`define REG_LOCKDET     4'h3
`define REG_CTRL        4'h4
`define REG_DIAG        4'h6

// ****************************************************************
// Field positions
// ****************************************************************
`define FREQ_PCODE_SEL  31
`define GAIN_NORM       4:0
`define GAIN_BOOST      12:8
`define SETTLE_COUNT    15:0
`define LD_DELAY        3:0
`define LD_WINDOW       11:4
`define LD_ERR_THR      19:12
`define LD_PASS_THR     27:20
`define CTRL_INT_OSC    0
`define CTRL_PWDN       1
`define CTRL_GATE_OVR   2
`define CTRL_EN_OVR     3
`define CTRL_MUX_SRC    5:4
`define CTRL_LD_SRC     7:6
`define DIAG_PTR        8:5
`define DIAG_STORE_MASK 32'h0000FFFF

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_FREQ        32'h80000000
`define RST_GAIN        32'h00001F03
`define RST_SETTLE      32'h00000100
`define RST_LOCKDET     32'h00404100
`define RST_CTRL        32'h00000001
`define RST_OTHER       32'h00000000

// ****************************************************************
// Pin sources, readback and part code
// ****************************************************************
`define SRC_LOW         2'h0
`define SRC_DLOCK       2'h1
`define SRC_VLOCK       2'h2
`define SRC_READBACK    2'h3
`define RB_ADDR_ONES    4'hF
`define RB_WORD_BITS    6'h20
// Arbitrary neutral part code base
`define PART_CODE_BASE  32'h00000A00
`define PASS_MULT_SHIFT 3

`endif

// [hdl/fast_settle_timer.v]
// Timeout counter that holds the fast-settle state after a start pulse.
// Assumes start is a one-cycle pulse on mclk; count is in mclk cycles.
`timescale 1ns/100ps
`default_nettype none

module fast_settle_timer #(
  parameter CW = 16
) (
  // Clock and reset
  input  wire          mclk,
  input  wire          nrst,
  // Control
  input  wire          start,
  input  wire [CW-1:0] count,
  // State
  output reg           active
);

  reg [CW-1:0] left_r;

  // ****************************************************************
  // Countdown
  // ****************************************************************
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      left_r <= {CW{1'b0}};
      active <= 1'b0;
    end else if (start) begin
      left_r <= count;
      active <= (count != {CW{1'b0}});
    end else if (active) begin
      left_r <= left_r - {{(CW-1){1'b0}}, 1'b1};
      if (left_r <= {{(CW-1){1'b0}}, 1'b1}) begin
        active <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// [hdl/phase_lock_counter.v]
// Digital lock check: counts failing and passing phase comparisons.
// Assumes one comparison per strobe cycle, all inputs on mclk.
`timescale 1ns/100ps
`default_nettype none

module phase_lock_counter #(
  parameter EW = 8,
  parameter TW = 8
) (
  // Clock and reset
  input  wire          mclk,
  input  wire          nrst,
  // Comparison
  input  wire          strobe,
  input  wire [EW-1:0] phase_err,
  input  wire [3:0]    detector_delay_setting,
  input  wire [EW-1:0] phase_error_window,
  // Thresholds
  input  wire [TW-1:0] unlock_error_threshold,
  input  wire [TW-1:0] lock_pass_threshold,
  // Result
  output reg           locked
);

  reg  [TW-1:0]   err_cnt_r;
  reg  [TW+2:0]   pass_cnt_r;
  wire [EW:0]     err_sum  = {1'b0, phase_err} + {{(EW-3){1'b0}}, detector_delay_setting};
  wire            fail     = err_sum > {1'b0, phase_error_window};
  wire [TW-1:0]   err_nxt  = err_cnt_r + {{(TW-1){1'b0}}, 1'b1};
  wire [TW+2:0]   pass_nxt = pass_cnt_r + {{(TW+2){1'b0}}, 1'b1};
  wire [TW+2:0]   pass_goal = {lock_pass_threshold, 3'h0};

  // ****************************************************************
  // Counters
  // ****************************************************************
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      err_cnt_r  <= {TW{1'b0}};
      pass_cnt_r <= {(TW+3){1'b0}};
      locked     <= 1'b0;
    end else if (strobe) begin
      if (fail) begin
        pass_cnt_r <= {(TW+3){1'b0}};
        if (err_cnt_r != {TW{1'b1}}) begin
          err_cnt_r <= err_nxt;
        end
        if (err_nxt >= unlock_error_threshold) begin
          locked <= 1'b0;
        end
      end else if (pass_nxt >= pass_goal) begin
        locked     <= 1'b1;
        err_cnt_r  <= {TW{1'b0}};
        pass_cnt_r <= {(TW+3){1'b0}};
      end else begin
        pass_cnt_r <= pass_nxt;
      end
    end
  end

endmodule

`default_nettype wire

// [hdl/lock_assist_readback.v]
// Lock assist top: fast-settle control, lock indications, register
// file with bus and serial access, and serial readback.
// Assumes sclk, sdata, latch_strobe and the pins are asynchronous to
// mclk; the serial clock is well below a quarter of mclk.
// Notes on behaviour
// - Frequency write starts timed fast-settle state
// - Switch pin low in fast-settle, else released
// - Boosted gain in fast-settle, switched with pin
// - Error when phase plus delay exceeds window
// - Enough errors declare the loop unlocked
// - Eight times pass threshold locks, clears errors
// - Tuning lock only with internal oscillator
// - Lock indications invalid while powered down
// - Every register readable by serial readback
// - Select bit picks pointed register or code
// - Part code follows two pins, selected from reset
// - Software overrides gate and enable pins
// - Diagnostic register returns live status
// - Strobe rise presents MSB before clocking
// - Next bit after each serial clock rise
// - Register readback address field reads all ones, part code does not
// - Strobe held high blocks loading only
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "lock_assist_regs.vh"

module lock_assist_readback (
  // Clock and reset
  input  wire        mclk,
  input  wire        nrst,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Serial link
  input  wire        sclk,
  input  wire        sdata,
  input  wire        latch_strobe,
  // Readback capable pins
  output reg         multipurpose_output_pin,
  output reg         lock_indicator_pin,
  // Device pins
  input  wire        output_buffer_gate_pin,
  input  wire        device_enable_pin,
  // Phase detector and tuning comparators
  input  wire        pd_strobe,
  input  wire [7:0]  pd_phase_err,
  input  wire        vtune_below,
  input  wire        vtune_above,
  // Fast-settle outputs
  output reg         fast_settle_switch_pin_o,
  output reg         fast_settle_switch_pin_oe,
  output reg  [4:0]  pump_gain,
  // Status outputs
  output reg         buffers_on,
  output reg         powered_down,
  output reg         digital_lock,
  output reg         vtune_lock
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam NS = 7;
  localparam S_SCLK = 0;
  localparam S_SDAT = 1;
  localparam S_LE   = 2;
  localparam S_GATE = 3;
  localparam S_EN   = 4;
  localparam S_VLO  = 5;
  localparam S_VHI  = 6;

  wire [NS-1:0] async_in = {vtune_above, vtune_below, device_enable_pin,
                            output_buffer_gate_pin, latch_strobe, sdata, sclk};
  reg  [NS-1:0] sync1_r;
  reg  [NS-1:0] sync2_r;
  reg           sclk_d_r;
  reg           le_d_r;

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi = gi + 1) begin : g_sync
      always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= async_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sclk_d_r <= 1'b0;
      le_d_r   <= 1'b0;
    end else begin
      sclk_d_r <= sync2_r[S_SCLK];
      le_d_r   <= sync2_r[S_LE];
    end
  end

  wire sclk_rise = sync2_r[S_SCLK] & ~sclk_d_r;
  wire le_rise   = sync2_r[S_LE] & ~le_d_r;
  wire le_level  = sync2_r[S_LE];

  // ****************************************************************
  // Register storage
  // ****************************************************************
  reg  [31:0] regs_r [0:15];
  reg  [31:0] in_sr_r;
  reg  [5:0]  in_cnt_r;
  wire        ser_load = le_rise & (in_cnt_r == `RB_WORD_BITS);
  wire        wr_en    = reg_wr | ser_load;
  wire [3:0]  wr_idx   = reg_wr ? reg_addr : in_sr_r[3:0];
  wire [31:0] wr_data  = reg_wr ? reg_wdata : in_sr_r;
  wire        freq_wr  = wr_en & (wr_idx == `REG_FREQ);

  wire [31:0] r_gain = regs_r[`REG_GAIN];
  wire [31:0] r_ld   = regs_r[`REG_LOCKDET];
  wire [31:0] r_ctrl = regs_r[`REG_CTRL];

  function [31:0] reset_word;
    input [3:0] idx;
    begin
      case (idx)
        `REG_FREQ:    reset_word = `RST_FREQ;
        `REG_GAIN:    reset_word = `RST_GAIN;
        `REG_SETTLE:  reset_word = `RST_SETTLE;
        `REG_LOCKDET: reset_word = `RST_LOCKDET;
        `REG_CTRL:    reset_word = `RST_CTRL;
        default:      reset_word = `RST_OTHER;
      endcase
    end
  endfunction

  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_regs
      localparam [3:0] IDX = gi;
      always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          regs_r[gi] <= reset_word(IDX);
        end else if (wr_en && wr_idx == IDX) begin
          regs_r[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Serial load path
  // ****************************************************************
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      in_sr_r  <= 32'h00000000;
      in_cnt_r <= 6'h00;
    end else if (le_rise) begin
      in_cnt_r <= 6'h00;
    end else if (sclk_rise && !le_level) begin
      in_sr_r <= {in_sr_r[30:0], sync2_r[S_SDAT]};
      if (in_cnt_r != `RB_WORD_BITS) begin
        in_cnt_r <= in_cnt_r + 6'h01;
      end
    end
  end

  // ****************************************************************
  // Pin overrides and powerdown
  // ****************************************************************
  wire gate_eff = r_ctrl[`CTRL_GATE_OVR] | sync2_r[S_GATE];
  wire en_eff   = r_ctrl[`CTRL_EN_OVR] | sync2_r[S_EN];
  wire pd_eff   = r_ctrl[`CTRL_PWDN] | ~en_eff;

  // ****************************************************************
  // Fast-settle and lock detection
  // ****************************************************************
  wire fs_active;
  wire dl_raw;

  fast_settle_timer #(
    .CW (16)
  ) u_timer (
    .mclk   (mclk),
    .nrst   (nrst),
    .start  (freq_wr),
    .count  (regs_r[`REG_SETTLE][`SETTLE_COUNT]),
    .active (fs_active)
  );

  phase_lock_counter #(
    .EW (8),
    .TW (8)
  ) u_lock (
    .mclk                   (mclk),
    .nrst                   (nrst),
    .strobe                 (pd_strobe),
    .phase_err              (pd_phase_err),
    .detector_delay_setting (r_ld[`LD_DELAY]),
    .phase_error_window     (r_ld[`LD_WINDOW]),
    .unlock_error_threshold (r_ld[`LD_ERR_THR]),
    .lock_pass_threshold    (r_ld[`LD_PASS_THR]),
    .locked                 (dl_raw)
  );

  wire vt_raw = r_ctrl[`CTRL_INT_OSC] & ~sync2_r[S_VLO] & ~sync2_r[S_VHI];

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fast_settle_switch_pin_o  <= 1'b0;
      fast_settle_switch_pin_oe <= 1'b0;
      pump_gain                 <= 5'h00;
      buffers_on                <= 1'b0;
      powered_down              <= 1'b1;
      digital_lock              <= 1'b0;
      vtune_lock                <= 1'b0;
    end else begin
      fast_settle_switch_pin_o  <= 1'b0;
      fast_settle_switch_pin_oe <= fs_active;
      pump_gain                 <= fs_active ? r_gain[`GAIN_BOOST]
                                             : r_gain[`GAIN_NORM];
      buffers_on                <= gate_eff & ~pd_eff;
      powered_down              <= pd_eff;
      digital_lock              <= dl_raw & ~pd_eff;
      vtune_lock                <= vt_raw & ~pd_eff;
    end
  end

  // ****************************************************************
  // Readback word selection
  // ****************************************************************
  wire [15:0] diag = {8'h00, fs_active, dl_raw, vt_raw, sync2_r[S_VHI],
                      sync2_r[S_VLO], pd_eff, en_eff, gate_eff};

  function [31:0] reg_word;
    input [3:0] idx;
    begin
      if (idx == `REG_DIAG) begin
        reg_word = (regs_r[`REG_DIAG] & `DIAG_STORE_MASK) | {diag, 16'h0000};
      end else begin
        reg_word = regs_r[idx];
      end
    end
  endfunction

  wire [31:0] ptr_word  = reg_word(regs_r[`REG_DIAG][`DIAG_PTR]);
  wire [31:0] part_code = `PART_CODE_BASE |
                          {24'h000000, 2'h0, sync2_r[S_GATE], sync2_r[S_EN], 4'h0};
  wire [31:0] rb_word   = regs_r[`REG_FREQ][`FREQ_PCODE_SEL] ? part_code
                          : {ptr_word[31:4], `RB_ADDR_ONES};

  // ****************************************************************
  // Serial readback shifter
  // ****************************************************************
  reg [31:0] rb_sr_r;
  reg [5:0]  rb_left_r;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rb_sr_r   <= 32'h00000000;
      rb_left_r <= 6'h00;
    end else if (le_rise) begin
      rb_sr_r   <= rb_word;
      rb_left_r <= `RB_WORD_BITS;
    end else if (sclk_rise && rb_left_r != 6'h00) begin
      rb_sr_r   <= {rb_sr_r[30:0], 1'b0};
      rb_left_r <= rb_left_r - 6'h01;
    end
  end

  function pin_level;
    input [1:0] src;
    begin
      case (src)
        `SRC_DLOCK:    pin_level = dl_raw & ~pd_eff;
        `SRC_VLOCK:    pin_level = vt_raw & ~pd_eff;
        `SRC_READBACK: pin_level = rb_sr_r[31];
        default:       pin_level = 1'b0;
      endcase
    end
  endfunction

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      multipurpose_output_pin <= 1'b0;
      lock_indicator_pin      <= 1'b0;
    end else begin
      multipurpose_output_pin <= pin_level(r_ctrl[`CTRL_MUX_SRC]);
      lock_indicator_pin      <= pin_level(r_ctrl[`CTRL_LD_SRC]);
    end
  end

  // ****************************************************************
  // Register port read
  // ****************************************************************
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= reg_word(reg_addr);
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

`default_nettype wire

// [tb/serial_host.sv]
// Host side of the serial link: shifts words in, samples readback bits.
// Assumes the bench picks the readback pin and programs its source.
`timescale 1ns/100ps
`default_nettype none

module serial_host (
  // Link
  output logic      sclk,
  output logic      sdata,
  output logic      latch_strobe,
  // Readback
  input  wire logic rb_pin
);
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    latch_strobe = 1'b0;
  end

  // ****************************************************************
  // One frame: strobe rise, 32 clocks, strobe rise or drop
  // ****************************************************************
  task automatic frame(input logic hold, input logic [31:0] din,
                       output logic [31:0] dout);
    latch_strobe = 1'b1;
    #200;
    latch_strobe = hold;
    for (int i = 31; i >= 0; i--) begin
      // Late sample, clear of the device's sync delay
      dout[i] = rb_pin;
      sdata = din[i];
      #100 sclk = 1'b1;
      #100 sclk = 1'b0;
    end
    sdata = ~din[0];
    latch_strobe = 1'b1;
    #200 latch_strobe = 1'b0;
    #200;
  endtask
endmodule

`default_nettype wire

// [tb/lock_assist_readback_props.sv]
// Checker of the lock assist block, bound to its top ports.
// Assumes a nonzero settle count of at least 8 cycles.
`timescale 1ns/100ps
`default_nettype none

module lock_assist_props (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        nrst,
  // Bus and loop inputs
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        pd_strobe,
  input wire logic        vtune_below,
  input wire logic        vtune_above,
  // Outputs
  input wire logic        fast_settle_switch_pin_o,
  input wire logic        fast_settle_switch_pin_oe,
  input wire logic [4:0]  pump_gain,
  input wire logic        buffers_on,
  input wire logic        powered_down,
  input wire logic        digital_lock,
  input wire logic        vtune_lock
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence freq_write;
    reg_wr && reg_addr == 4'h0;
  endsequence
  sequence out_of_range;
    (vtune_below || vtune_above) [*6];
  endsequence

  a_switch_low: assert property (
    fast_settle_switch_pin_oe |-> !fast_settle_switch_pin_o)
    else $error("switch pin driven high");
  a_settle_start: assert property (
    freq_write |-> ##[1:4] fast_settle_switch_pin_oe)
    else $error("no fast settle after frequency write");
  a_settle_hold: assert property (
    $rose(fast_settle_switch_pin_oe) |-> fast_settle_switch_pin_oe [*8])
    else $error("fast settle cut short");
  a_gain_switch: assert property (
    $changed(fast_settle_switch_pin_oe) |-> $changed(pump_gain))
    else $error("gain not switched with pin");
  a_pwdn_lock: assert property (
    powered_down && $past(powered_down) |-> !digital_lock && !vtune_lock)
    else $error("lock shown while powered down");
  a_pwdn_buffers: assert property (
    powered_down && $past(powered_down) |-> !buffers_on)
    else $error("buffers on while powered down");
  a_vtune_unlock: assert property (
    out_of_range |-> !vtune_lock)
    else $error("tuning lock while out of range");
  a_lock_cause: assert property (
    $rose(digital_lock) |-> $past(pd_strobe) || $past(pd_strobe, 2)
      || $past(pd_strobe, 3) || $past(pd_strobe, 4)
      || $past(powered_down) || $past(powered_down, 2))
    else $error("lock without comparisons");
  a_rdata_quiet: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h00000000)
    else $error("read data outside read");
endmodule

bind lock_assist_readback lock_assist_props chk_u (
  .mclk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .pd_strobe,
  .vtune_below, .vtune_above, .fast_settle_switch_pin_o,
  .fast_settle_switch_pin_oe, .pump_gain, .buffers_on, .powered_down,
  .digital_lock, .vtune_lock
);

`default_nettype wire

// [tb/lock_assist_readback_test.sv]
// Self-checking bench of the lock assist and readback block.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "lock_assist_regs.vh"

module lock_assist_readback_test;
  logic        mclk, nrst, reg_wr, reg_rd, sclk, sdata, latch_strobe;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic        multipurpose_output_pin, lock_indicator_pin, use_lock, rb_pin;
  logic        output_buffer_gate_pin, device_enable_pin, pd_strobe;
  logic [7:0]  pd_phase_err;
  logic        vtune_below, vtune_above, fast_settle_switch_pin_o;
  logic        fast_settle_switch_pin_oe, buffers_on, powered_down;
  logic        digital_lock, vtune_lock, switch_level;
  logic [4:0]  pump_gain;
  int          mismatches, tests_run;

  assign rb_pin = use_lock ? lock_indicator_pin : multipurpose_output_pin;
  assign switch_level = fast_settle_switch_pin_oe ? fast_settle_switch_pin_o : 1'bz;

  lock_assist_readback dut_u (
    .mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sclk, .sdata, .latch_strobe, .multipurpose_output_pin,
    .lock_indicator_pin, .output_buffer_gate_pin, .device_enable_pin,
    .pd_strobe, .pd_phase_err, .vtune_below, .vtune_above,
    .fast_settle_switch_pin_o, .fast_settle_switch_pin_oe, .pump_gain,
    .buffers_on, .powered_down, .digital_lock, .vtune_lock
  );
  serial_host host_u (.sclk, .sdata, .latch_strobe, .rb_pin);

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge mclk);
  endtask
  task automatic ser(input logic hold, input logic [31:0] din,
                     output logic [31:0] dout);
    #3 host_u.frame(hold, din, dout);
    @(posedge mclk);
  endtask
  task automatic pd(input logic [7:0] e, input int n);
    repeat (n) begin
      pd_phase_err <= e;
      pd_strobe <= 1'b1;
      @(posedge mclk);
    end
    pd_strobe <= 1'b0;
    repeat (5) @(posedge mclk);
  endtask
  task automatic settle6;
    repeat (6) @(posedge mclk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    logic [31:0] v;
    logic [31:0] rv [6];
    rv = '{`RST_FREQ, `RST_GAIN, `RST_SETTLE, `RST_LOCKDET, `RST_CTRL, `RST_OTHER};
    for (int i = 0; i < 6; i++) begin
      rd(i < 5 ? i[3:0] : 4'hF, v);
      check(v, rv[i]);
    end
    $display("test reset done");
  endtask
  task automatic t_part;
    logic [31:0] v;
    wr(`REG_CTRL, 32'h000000F1);
    for (int i = 0; i < 4; i++) begin
      output_buffer_gate_pin <= i[1];
      device_enable_pin <= i[0];
      use_lock <= i[0];
      settle6;
      ser(1'b1, 32'hFFFFFFFF, v);
      check(v, `PART_CODE_BASE | (i << 4));
    end
    output_buffer_gate_pin <= 1'b1;
    device_enable_pin <= 1'b1;
    rd(4'hF, v);
    check(v, 32'h00000000);
    $display("test part code done");
  endtask
  task automatic t_readback;
    logic [31:0] v;
    wr(`REG_FREQ, 32'h00000000);
    wr(`REG_GAIN, 32'h00001A05);
    wr(`REG_DIAG, 32'h00000020);
    ser(1'b1, 32'h00000000, v);
    check(v, 32'h00001A0F);
    wr(`REG_DIAG, 32'h000000C0);
    ser(1'b0, 32'h000000C6, v);
    check(v[15:0], 16'h00CF);
    check(v[31:24], 8'h00);
    rd(`REG_DIAG, v);
    check(v[15:0], 16'h00C6);
    ser(1'b0, 32'h00000B11, v);
    ser(1'b1, 32'h00000A51, v);
    rd(`REG_GAIN, v);
    check(v, 32'h00000B11);
    $display("test readback done");
  endtask
  task automatic t_settle;
    int n;
    wr(`REG_SETTLE, 32'h00000014);
    wr(`REG_GAIN, 32'h00001A05);
    wr(`REG_FREQ, 32'h00000000);
    n = 0;
    while (fast_settle_switch_pin_oe !== 1'b1 && n < 10) begin
      @(posedge mclk);
      #1 n++;
    end
    check(pump_gain, 5'h1A);
    check(switch_level, 1'b0);
    // First active cycle already seen above
    n = 1;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (fast_settle_switch_pin_oe === 1'b1 && n < 100);
    check(n, 20);
    check(pump_gain, 5'h05);
    check(switch_level, 1'bz);
    @(posedge mclk);
    $display("test fast settle done");
  endtask
  task automatic t_lock;
    wr(`REG_CTRL, 32'h00000001);
    wr(`REG_LOCKDET, 32'h001030A2);
    pd(8'h08, 7);
    check(digital_lock, 1'b0);
    pd(8'h08, 1);
    check(digital_lock, 1'b1);
    pd(8'h09, 2);
    check(digital_lock, 1'b1);
    pd(8'h09, 1);
    check(digital_lock, 1'b0);
    pd(8'h08, 8);
    pd(8'h09, 2);
    check(digital_lock, 1'b1);
    wr(`REG_CTRL, 32'h00000091);
    settle6;
    check({multipurpose_output_pin, lock_indicator_pin}, 2'b11);
    wr(`REG_CTRL, 32'h00000093);
    settle6;
    check({powered_down, digital_lock}, 2'b10);
    check({multipurpose_output_pin, lock_indicator_pin}, 2'b00);
    $display("test lock detect done");
  endtask
  task automatic t_pins;
    wr(`REG_CTRL, 32'h00000001);
    settle6;
    check(vtune_lock, 1'b1);
    vtune_above <= 1'b1;
    settle6;
    check(vtune_lock, 1'b0);
    vtune_above <= 1'b0;
    vtune_below <= 1'b1;
    settle6;
    check(vtune_lock, 1'b0);
    vtune_below <= 1'b0;
    wr(`REG_CTRL, 32'h00000000);
    settle6;
    check(vtune_lock, 1'b0);
    output_buffer_gate_pin <= 1'b0;
    device_enable_pin <= 1'b0;
    settle6;
    check({buffers_on, powered_down}, 2'b01);
    wr(`REG_CTRL, 32'h0000000C);
    settle6;
    check({buffers_on, powered_down}, 2'b10);
    $display("test pins done");
  endtask

  task automatic summarize;
    $display("counts: %0d compares, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, use_lock} = '0;
    {pd_strobe, pd_phase_err, vtune_below, vtune_above} = '0;
    output_buffer_gate_pin = 1'b1;
    device_enable_pin = 1'b1;
    mismatches = 0;
    tests_run = 0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_part;
    t_readback;
    t_settle;
    t_lock;
    t_pins;
    summarize;
  end
  initial begin
    #500000;
    mismatches++;
    summarize;
  end
endmodule

`default_nettype wire
